//--- hdm_mailbox.sv
// Two-channel host DMA mailbox top and its stream FIFO
`timescale 1ns/100ps
`include "hdm_consts.svh"
// Parameterised valid/ready FIFO
module hdm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;
    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    // Storage, no reset needed
    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem_r[wp_r] <= in_data;
        end
    end
    // Pointers and fill count
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
            end
            if (pop)
            begin
                rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module hdm_mailbox (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Local processor I/O port
    input wire hdm_pkg::hdm_cpu_req_t cpu_req,
    output logic [7:0] cpu_rdata,
    // Host strobes per channel
    input wire hdm_pkg::hdm_host_strb_t host_strb_ch0,
    input wire hdm_pkg::hdm_host_strb_t host_strb_ch1,
    input wire logic uart_access,
    // Host data bus
    input wire logic [7:0] host_data_bus_in,
    output logic [7:0] host_data_bus_out,
    output logic host_data_bus_oe,
    // Request pins, buffer disable, uart select and pin functions
    output logic dma_req_pin_ch0,
    output logic dma_req_pin_ch0_oe,
    output logic dma_req_pin_ch1,
    output logic dma_req_pin_ch1_oe,
    output logic data_buffer_disable_n,
    output logic uart_host_select_n,
    output logic [1:0] pin_func_alt,
    // Transmit byte stream to local logic
    output logic tx_stream_valid,
    input wire logic tx_stream_ready,
    output logic [7:0] tx_stream_data
);
    logic [1:0] req_r;
    logic [1:0] en_r;
    logic [1:0] mux_r;
    logic rev_avail_r;
    logic wr_rev_r;
    logic [7:0] tx_mbox_r [2];
    logic [7:0] rx_mbox_r [2];
    logic [1:0] ack_n;
    logic [1:0] rd_n;
    logic [1:0] wr_n;
    logic [1:0] rd_n_d_r;
    logic [1:0] wr_n_d_r;
    logic [1:0] rd_rise;
    logic [1:0] wr_rise;
    logic [1:0] rd_act;
    logic [1:0] wr_act;
    logic [1:0] strb_low;
    logic ctrl_wr;
    logic fifo_in_ready;
    logic fifo_push;
    logic [7:0] fifo_data;
    assign ack_n = {host_strb_ch1.ack_n, host_strb_ch0.ack_n};
    assign rd_n = {host_strb_ch1.rd_n, host_strb_ch0.rd_n};
    assign wr_n = {host_strb_ch1.wr_n, host_strb_ch0.wr_n};
    assign ctrl_wr = cpu_req.wr && (cpu_req.addr == `HDM_ADDR_CTRL);
    // Per-channel strobe decode and mailbox behaviour
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_ch
            logic sw_wr;
            logic we_bit;
            logic req_bit;
            logic [7:0] mb_addr;
            assign mb_addr = (ch == 0) ? `HDM_ADDR_MBOX0 : `HDM_ADDR_MBOX1;
            assign we_bit = cpu_req.wdata[ch == 0 ? `HDM_BIT_WE0 : `HDM_BIT_WE1];
            assign req_bit = cpu_req.wdata[ch == 0 ? `HDM_BIT_REQ0 : `HDM_BIT_REQ1];
            assign sw_wr = ctrl_wr && we_bit;
            assign rd_act[ch] = en_r[ch] && !ack_n[ch] && !rd_n[ch];
            assign wr_act[ch] = en_r[ch] && !ack_n[ch] && !wr_n[ch];
            assign rd_rise[ch] = !ack_n[ch] && rd_n[ch] && !rd_n_d_r[ch];
            assign wr_rise[ch] = !ack_n[ch] && wr_n[ch] && !wr_n_d_r[ch];
            assign strb_low[ch] = !ack_n[ch] && (!rd_n[ch] || !wr_n[ch]);
            always_ff @(posedge clk_sys)
            begin
                if (!rst_b)
                begin
                    req_r[ch] <= 1'b0;
                end
                else if (sw_wr)
                begin
                    req_r[ch] <= req_bit;
                end
                else if (rd_rise[ch] || wr_rise[ch])
                begin
                    req_r[ch] <= 1'b0;
                end
            end
            always_ff @(posedge clk_sys)
            begin
                if (!rst_b)
                begin
                    rx_mbox_r[ch] <= `HDM_BYTE_ZERO;
                end
                else if (cpu_req.wr && cpu_req.addr == mb_addr)
                begin
                    rx_mbox_r[ch] <= cpu_req.wdata;
                end
            end
            always_ff @(posedge clk_sys)
            begin
                if (!rst_b)
                begin
                    rd_n_d_r[ch] <= 1'b1;
                    wr_n_d_r[ch] <= 1'b1;
                end
                else
                begin
                    rd_n_d_r[ch] <= rd_n[ch];
                    wr_n_d_r[ch] <= wr_n[ch];
                end
            end
        end
    endgenerate
    // Control register: enables and pin selects
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            en_r <= 2'b00;
            mux_r <= 2'b00;
        end
        else if (ctrl_wr && !cpu_req.wdata[`HDM_BIT_WE1] && !cpu_req.wdata[`HDM_BIT_WE0])
        begin
            en_r <= {cpu_req.wdata[`HDM_BIT_EN1], cpu_req.wdata[`HDM_BIT_EN0]};
            mux_r <= {cpu_req.wdata[`HDM_BIT_MUX1], cpu_req.wdata[`HDM_BIT_MUX0]};
        end
    end
    // Revision flags cleared by first read of their mailbox: bit 6 by D0h, bit 7 by D1h
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            rev_avail_r <= 1'b1;
            wr_rev_r <= 1'b1;
        end
        else
        begin
            if (cpu_req.rd && cpu_req.addr == `HDM_ADDR_MBOX0)
            begin
                rev_avail_r <= 1'b0;
            end
            if (cpu_req.rd && cpu_req.addr == `HDM_ADDR_MBOX1)
            begin
                wr_rev_r <= 1'b0;
            end
        end
    end
    // Transmit mailboxes latch at write strobe rise
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            tx_mbox_r[0] <= `HDM_REV_CODE;
            tx_mbox_r[1] <= `HDM_BYTE_ZERO;
        end
        else
        begin
            if (wr_rise[0] && en_r[0] && !wr_n_d_r[0])
            begin
                tx_mbox_r[0] <= host_data_bus_in;
            end
            else if (cpu_req.rd && cpu_req.addr == `HDM_ADDR_MBOX0 && rev_avail_r)
            begin
                tx_mbox_r[0] <= `HDM_BYTE_ZERO;
            end
            if (wr_rise[1] && en_r[1])
            begin
                tx_mbox_r[1] <= host_data_bus_in;
            end
        end
    end
    // Completed host writes also feed the stream FIFO
    // Full buffer drops the byte
    assign fifo_push = ((wr_rise[0] && en_r[0]) || (wr_rise[1] && en_r[1])) && fifo_in_ready;
    assign fifo_data = host_data_bus_in;
    hdm_fifo #(
        .WIDTH(8),
        .DEPTH(`HDM_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(fifo_data),
        .out_valid(tx_stream_valid),
        .out_ready(tx_stream_ready),
        .out_data(tx_stream_data)
    );
    // Processor read data
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            cpu_rdata <= `HDM_BYTE_ZERO;
        end
        else if (cpu_req.rd)
        begin
            unique case (cpu_req.addr)
                `HDM_ADDR_MBOX0: cpu_rdata <= tx_mbox_r[0];
                `HDM_ADDR_MBOX1: cpu_rdata <= tx_mbox_r[1];
                `HDM_ADDR_CTRL: cpu_rdata <= {wr_rev_r, rev_avail_r, req_r, mux_r, en_r};
                default: cpu_rdata <= `HDM_BYTE_ZERO;
            endcase
        end
    end
    // Host pins, all registered
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            host_data_bus_out <= `HDM_BYTE_ZERO;
            host_data_bus_oe <= 1'b0;
            dma_req_pin_ch0 <= 1'b0;
            dma_req_pin_ch1 <= 1'b0;
            dma_req_pin_ch0_oe <= 1'b0;
            dma_req_pin_ch1_oe <= 1'b0;
            data_buffer_disable_n <= 1'b1;
            uart_host_select_n <= 1'b1;
            pin_func_alt <= 2'b00;
        end
        else
        begin
            host_data_bus_out <= rd_act[1] ? rx_mbox_r[1] : rx_mbox_r[0];
            host_data_bus_oe <= |rd_act;
            dma_req_pin_ch0 <= req_r[0] && en_r[0] && ack_n[0] && !strb_low[0];
            dma_req_pin_ch1 <= req_r[1] && en_r[1] && ack_n[1] && !strb_low[1];
            dma_req_pin_ch0_oe <= en_r[0] && !mux_r[0];
            dma_req_pin_ch1_oe <= en_r[1] && !mux_r[1];
            data_buffer_disable_n <= ~|rd_act;
            uart_host_select_n <= !(uart_access && !(|(en_r & ~ack_n)));
            pin_func_alt <= mux_r;
        end
    end
endmodule

//--- hdm_consts.svh
// Constants for the two-channel host DMA mailbox
// Contract
// - Read strobe fall drops pin, keeps bit
// - Drive receive mailbox during ack read
// - Read strobe rise releases bus, clears bit
// - Buffer disable low during mailbox read
// - Bit set by write, cleared several ways
// - Pin high only when bit and enable
// - Transmit mailbox captures during write strobe; the code latches it only at the write strobe rise
// - Receive mailbox drives only when enabled
// - Bit 7 qualifies channel 1 bit write
// - Bit 6 qualifies channel 0 bit write
// - Bit 7 reads set until mailbox read
// - Bit 6 shows revision data present
// - Channel 0 mailbox powers up with revision
// - Channel 1 request bit at position 5
// - Channel 0 request bit at position 4
// - Bit 3 selects channel 1 pin function
// - Bit 2 selects channel 0 pin function
// - Bit 1 enables channel 1 request output
// - Bit 0 enables channel 0 request output
// - D0h and D1h mailbox addresses
// - Write strobe rise latches and clears bit
// - No uart select during enabled acknowledge
`ifndef HDM_CONSTS_SVH
`define HDM_CONSTS_SVH
`define HDM_ADDR_MBOX0 8'hd0
`define HDM_ADDR_MBOX1 8'hd1
`define HDM_ADDR_CTRL 8'hd2
`define HDM_BIT_WE1 7
`define HDM_BIT_WE0 6
`define HDM_BIT_REQ1 5
`define HDM_BIT_REQ0 4
`define HDM_BIT_MUX1 3
`define HDM_BIT_MUX0 2
`define HDM_BIT_EN1 1
`define HDM_BIT_EN0 0
`define HDM_LOW_MASK 4'h0
`define HDM_BYTE_ZERO 8'h00
`define HDM_REV_CODE 8'h5a
`define HDM_FIFO_DEPTH 8
`endif

//--- hdm_pkg.sv
// Types for the two-channel host DMA mailbox
package hdm_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hdm_cpu_req_t;
    typedef struct packed {
        logic ack_n;
        logic rd_n;
        logic wr_n;
    } hdm_host_strb_t;
    typedef enum logic [2:0] {
        HDM_IDLE = 3'b001,
        HDM_RD = 3'b010,
        HDM_WR = 3'b100
    } hdm_cyc_t;
endpackage

//--- hdm_fifo.sv
// Stream FIFO module lives in the mailbox top file with the rest of the logic

//--- hdm_mailbox_asserts.sv
// Port assertions for the host DMA mailbox
`timescale 1ns/100ps
module hdm_mailbox_chk (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Watched ports
    input wire hdm_pkg::hdm_cpu_req_t cpu_req,
    input wire logic [7:0] cpu_rdata,
    input wire hdm_pkg::hdm_host_strb_t host_strb_ch0,
    input wire hdm_pkg::hdm_host_strb_t host_strb_ch1,
    input wire logic uart_access,
    input wire logic host_data_bus_oe,
    input wire logic dma_req_pin_ch0,
    input wire logic dma_req_pin_ch0_oe,
    input wire logic dma_req_pin_ch1,
    input wire logic dma_req_pin_ch1_oe,
    input wire logic data_buffer_disable_n,
    input wire logic uart_host_select_n
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    chk_ack_pin_low: assert property (!host_strb_ch0.ack_n |=> !dma_req_pin_ch0)
        else $error("pin high under ack");
    chk_pin_needs_en: assert property (!dma_req_pin_ch1_oe [*2] |-> !dma_req_pin_ch1)
        else $error("pin high while disabled");
    chk_req_sets_pin: assert property (
        cpu_req.wr && cpu_req.addr == 8'hd2 && cpu_req.wdata[6] && cpu_req.wdata[4]
        && dma_req_pin_ch0_oe && host_strb_ch0.ack_n ##1 host_strb_ch0.ack_n && !cpu_req.wr
        |=> dma_req_pin_ch0) else $error("request write did not raise pin");
    chk_read_drives: assert property (
        !host_strb_ch0.ack_n && !host_strb_ch0.rd_n && dma_req_pin_ch0_oe |=> host_data_bus_oe)
        else $error("bus not driven in read");
    chk_buf_dis_low: assert property (host_data_bus_oe |-> !data_buffer_disable_n)
        else $error("buffer disable high while driving");
    chk_bus_release: assert property (
        (host_strb_ch0.rd_n && host_strb_ch1.rd_n) [*2] |=> !host_data_bus_oe)
        else $error("bus still driven");
    chk_uart_blocked: assert property (
        uart_access && !host_strb_ch0.ack_n && dma_req_pin_ch0_oe |=> uart_host_select_n)
        else $error("uart select during ack");
    chk_unmapped_zero: assert property (
        cpu_req.rd && !(cpu_req.addr inside {8'hd0, 8'hd1, 8'hd2}) |=> cpu_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_rev_flag: assert property (
        cpu_req.rd && cpu_req.addr == 8'hd0 ##2 cpu_req.rd && cpu_req.addr == 8'hd2
        |=> !cpu_rdata[6]) else $error("revision flag kept");
    cov_host_write: cover property (!host_strb_ch0.ack_n && !host_strb_ch0.wr_n);
    cov_host_read: cover property (host_data_bus_oe);
    cov_pin_ch1: cover property (dma_req_pin_ch1);
endmodule

//--- hdm_host_dma.sv
// Behavioural host DMA controller: acknowledge, strobes and data
`timescale 1ns/100ps
module hdm_host_dma (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Request pins and bench control
    input wire logic [1:0] req_pin,
    input wire logic [1:0] req_oe,
    input wire logic chan,
    input wire logic do_write,
    input wire logic [7:0] wbyte,
    input wire logic [3:0] lag,
    // Host bus
    output hdm_pkg::hdm_host_strb_t strb0,
    output hdm_pkg::hdm_host_strb_t strb1,
    output logic [7:0] hdata_out,
    input wire logic [7:0] hdata_in,
    input wire logic hdata_oe,
    output logic [7:0] rbyte,
    output logic done
);
    hdm_pkg::hdm_host_strb_t s;
    logic [4:0] step;
    logic [4:0] base;
    assign base = {1'b0, lag};
    assign strb0 = chan ? 3'b111 : s;
    assign strb1 = chan ? s : 3'b111;
    // Outside an acknowledged write the bus carries the inverted byte, so a stale byte never matches
    assign hdata_out = (!s.ack_n && do_write) ? wbyte : ~wbyte;
    always_ff @(posedge clk_sys)
    begin
        done <= 1'b0;
        if (!rst_b)
        begin
            step <= 5'h00;
            s <= 3'b111;
        end
        else if (step != 5'h00 || (req_pin[chan] && req_oe[chan]))
        begin
            step <= step + 5'h01;
            if (step == base + 5'h01)
                s.ack_n <= 1'b0;
            if (step == base + 5'h02)
                s <= {1'b0, do_write, !do_write};
            if (step == base + 5'h04)
            begin
                rbyte <= hdata_oe ? hdata_in : ~wbyte;
                s <= 3'b011;
            end
            if (step == base + 5'h07)
                s.ack_n <= 1'b1;
            if (step == base + 5'h09)
            begin
                step <= 5'h00;
                done <= 1'b1;
            end
        end
    end
endmodule

//--- hdm_mailbox_test.sv
// Self-checking bench for the host DMA mailbox
`timescale 1ns/100ps
`include "hdm_consts.svh"
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_fail++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module hdm_mailbox_test;
    typedef struct packed {logic ch; logic wr; logic [7:0] d; logic [3:0] lag;} hdm_row_t;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic uart_access = 1'b0;
    logic tx_stream_ready = 1'b1;
    logic chan = 1'b0;
    logic do_write = 1'b0;
    logic [7:0] wbyte = 8'h00;
    logic [3:0] lag = 4'h0;
    hdm_pkg::hdm_cpu_req_t cpu_req = '0;
    hdm_pkg::hdm_host_strb_t host_strb_ch0, host_strb_ch1;
    logic [7:0] cpu_rdata, host_data_bus_in, host_data_bus_out, tx_stream_data, rbyte, v;
    logic host_data_bus_oe, dma_req_pin_ch0, dma_req_pin_ch0_oe, dma_req_pin_ch1, done;
    logic dma_req_pin_ch1_oe, data_buffer_disable_n, uart_host_select_n, tx_stream_valid;
    logic [1:0] pin_func_alt;
    int n_fail = 0;
    int cmp_count = 0;
    hdm_row_t rows [4] = '{'{1'b0, 1'b1, 8'ha5, 4'h0}, '{1'b1, 1'b1, 8'h3c, 4'h5},
        '{1'b0, 1'b0, 8'h96, 4'h1}, '{1'b1, 1'b0, 8'h0f, 4'h8}};
    hdm_mailbox hdm_mailbox_inst (.clk_sys, .rst_b, .cpu_req, .cpu_rdata, .host_strb_ch0,
        .host_strb_ch1, .uart_access, .host_data_bus_in, .host_data_bus_out, .host_data_bus_oe,
        .dma_req_pin_ch0, .dma_req_pin_ch0_oe, .dma_req_pin_ch1, .dma_req_pin_ch1_oe,
        .data_buffer_disable_n, .uart_host_select_n, .pin_func_alt, .tx_stream_valid,
        .tx_stream_ready, .tx_stream_data);
    hdm_host_dma hdm_host_dma_inst (.clk_sys, .rst_b, .req_pin({dma_req_pin_ch1,
        dma_req_pin_ch0}), .req_oe({dma_req_pin_ch1_oe, dma_req_pin_ch0_oe}), .chan,
        .do_write, .wbyte, .lag, .strb0(host_strb_ch0), .strb1(host_strb_ch1),
        .hdata_out(host_data_bus_in), .hdata_in(host_data_bus_out),
        .hdata_oe(host_data_bus_oe), .rbyte, .done);
    initial forever #50 clk_sys = ~clk_sys;
    task automatic report_and_stop();
        if (n_fail == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic give_up();
        n_fail++;
        report_and_stop();
    endtask
    // One processor access; read data lands in v
    task automatic cpu_op(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        cpu_req = {wr, !wr, a, d};
        @(negedge clk_sys);
        cpu_req.wr = 1'b0;
        cpu_req.rd = 1'b0;
        v = cpu_rdata;
    endtask
    task automatic dma(input hdm_row_t r);
        int k;
        chan = r.ch;
        do_write = r.wr;
        wbyte = r.d;
        lag = r.lag;
        if (!r.wr)
            cpu_op(1'b1, {7'h68, r.ch}, r.d);
        cpu_op(1'b1, 8'hd2, r.ch ? 8'ha3 : 8'h53);
        for (k = 0; k < 60 && done !== 1'b1; k++)
            @(negedge clk_sys);
        v = 8'hff;
        for (int j = 0; j < 9 && v[{2'b10, r.ch}] !== 1'b0; j++)
            cpu_op(1'b0, 8'hd2, 8'h00);
        if (k == 60 || v[{2'b10, r.ch}] !== 1'b0)
            give_up();
        cpu_op(1'b0, {7'h68, r.ch}, 8'h00);
        if (r.wr)
            `CHK(v, r.d)
        else
            `CHK(rbyte, r.d)
    endtask
    initial
    begin
        repeat (12) @(negedge clk_sys);
        rst_b = 1'b1;
        cpu_op(1'b0, 8'hd2, 8'h00);
        `CHK(v, 8'hc0)
        cpu_op(1'b0, 8'hd0, 8'h00);
        `CHK(v, `HDM_REV_CODE)
        cpu_op(1'b0, 8'hd2, 8'h00);
        `CHK(v, 8'h80)
        cpu_op(1'b0, 8'hd1, 8'h00);
        cpu_op(1'b0, 8'hd2, 8'h00);
        `CHK(v, 8'h00)
        cpu_op(1'b0, 8'hd7, 8'h00);
        `CHK(v, 8'h00)
        cpu_op(1'b1, 8'hd2, 8'h0f);
        cpu_op(1'b0, 8'hd2, 8'h00);
        `CHK({v, pin_func_alt}, 10'h03f)
        cpu_op(1'b1, 8'hd2, 8'h03);
        @(negedge clk_sys);
        `CHK({dma_req_pin_ch0_oe, dma_req_pin_ch1_oe, pin_func_alt}, 4'hc)
        cpu_op(1'b1, 8'hd2, 8'ha0);
        cpu_op(1'b0, 8'hd2, 8'h00);
        `CHK({v, dma_req_pin_ch1}, 9'h047)
        cpu_op(1'b1, 8'hd2, 8'h80);
        cpu_op(1'b1, 8'hd2, 8'h4c);
        cpu_op(1'b0, 8'hd2, 8'h00);
        `CHK({v, dma_req_pin_ch1}, 9'h006)
        foreach (rows[i])
            dma(rows[i]);
        chan = 1'b0;
        cpu_op(1'b1, 8'hd2, 8'h00);
        cpu_op(1'b1, 8'hd2, 8'h50);
        repeat (4) @(negedge clk_sys);
        `CHK({dma_req_pin_ch0, dma_req_pin_ch0_oe, done}, 3'h0)
        cpu_op(1'b1, 8'hd2, 8'h40);
        cpu_op(1'b0, 8'hd2, 8'h00);
        `CHK(v, 8'h00)
        // Fill the stream buffer past its depth while the drain stalls
        tx_stream_ready = 1'b0;
        uart_access = 1'b1;
        cpu_op(1'b1, 8'hd2, 8'h01);
        for (int i = 0; i < 9; i++)
            dma('{1'b0, 1'b1, 8'(i), 4'h0});
        tx_stream_ready = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            `CHK({tx_stream_valid, tx_stream_data}, 9'h100 + 9'(i))
            @(negedge clk_sys);
        end
        `CHK(tx_stream_valid, 1'b0)
        `CHK(uart_host_select_n, 1'b0)
        // Mid-run reset restores pins, flags and revision byte
        rst_b = 1'b0;
        repeat (2) @(negedge clk_sys);
        `CHK({host_data_bus_oe, dma_req_pin_ch0, dma_req_pin_ch0_oe}, 3'h0)
        `CHK({uart_host_select_n, data_buffer_disable_n}, 2'h3)
        rst_b = 1'b1;
        cpu_op(1'b0, 8'hd2, 8'h00);
        `CHK(v, 8'hc0)
        cpu_op(1'b0, 8'hd0, 8'h00);
        `CHK(v, `HDM_REV_CODE)
        report_and_stop();
    end
endmodule
bind hdm_mailbox hdm_mailbox_chk hdm_mailbox_chk_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .host_strb_ch0(host_strb_ch0),
    .host_strb_ch1(host_strb_ch1), .uart_access(uart_access),
    .host_data_bus_oe(host_data_bus_oe), .dma_req_pin_ch0(dma_req_pin_ch0),
    .dma_req_pin_ch0_oe(dma_req_pin_ch0_oe), .dma_req_pin_ch1(dma_req_pin_ch1),
    .dma_req_pin_ch1_oe(dma_req_pin_ch1_oe), .data_buffer_disable_n(data_buffer_disable_n),
    .uart_host_select_n(uart_host_select_n));
